// >>> core/wdg_regs.svh
// register offsets, field positions and reset values of the windowed watchdog
// assumes a 32-bit register port with word offsets as byte addresses
`ifndef WDG_REGS_SVH
`define WDG_REGS_SVH
`define WDG_OFS_CTRL        8'h00
`define WDG_OFS_MODE        8'h04
`define WDG_OFS_STAT        8'h08
`define WDG_KEY_VAL         8'hA5
`define WDG_KEY_HI          31
`define WDG_KEY_LO          24
`define WDG_RESTART_BIT     0
`define WDG_RSTEN_BIT       13
`define WDG_MODE_RESET      32'h3FFF2FFF
`define WDG_MODE_MASK       32'h3FFFFFFF
`define WDG_STAT_UNF_BIT    0
`define WDG_STAT_ERR_BIT    1
`define WDG_PRESCALE_DIV    128
`endif

// >>> core/wdg_pkg.sv
// types of the windowed watchdog: mode layout and register port bundle
// assumes the constants header is included by the design file
package wdg_pkg;
   typedef struct packed {
      logic [1:0]  rsvd;
      logic        idle_halt;
      logic        debug_halt;
      logic [11:0] window_limit;
      logic        disable_bit;
      logic        proc_only_reset;
      logic        fault_reset_enable;
      logic        fault_irq_enable;
      logic [11:0] reload_value;
   } wdg_mode_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } wdg_req_t;

   typedef enum logic [1:0] {
      WDG_RUN   = 2'b00,
      WDG_HALT  = 2'b01,
      WDG_OFF   = 2'b11
   } wdg_state_t;
endpackage : wdg_pkg

// >>> core/wdg_top.sv
// windowed watchdog timer with key-protected restart and write-once mode
// assumes REF_CLK carries the slow clock ticks via SLOW_TICK strobe
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`include "wdg_regs.svh"
module wdg_top
   import wdg_pkg::*;
#(
   parameter int PRESCALE = `WDG_PRESCALE_DIV
) (
   // clock, reset, enable
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   input  wire logic        BACKUP_RST_N,
   input  wire logic        CLK_EN,
   // slow clock tick and system states
   input  wire logic        SLOW_TICK,
   input  wire logic        DEBUG_STATE,
   input  wire logic        IDLE_STATE,
   // register port
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   // outputs to interrupt and reset control, and the counter value
   output logic             IRQ,
   output logic             FAULT,
   output logic             FAULT_PROC_ONLY,
   output logic [11:0]      COUNT
);
   logic       rs1_r;
   logic       rs_n_r;
   logic       bk1_r;
   logic       bk_n_r;
   wdg_req_t   req;
   wdg_mode_t  mode_r;
   logic       mode_locked_r;
   logic       rst_en_r;
   logic [11:0] cnt_r;
   logic [6:0] pre_r;
   logic       unf_r;
   logic       err_r;
   logic       fault_r;
   logic       proc_only_r;
   logic [31:0] rdata_r;
   wdg_state_t st;
   logic       wr_ctrl;
   logic       wr_mode;
   logic       rd_stat;
   logic       restart;
   logic       tick;
   logic       underflow;
   logic       win_err;

   // reset release through two flops
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rs1_r  <= 1'b0;
         rs_n_r <= 1'b0;
      end else begin
         rs1_r  <= 1'b1;
         rs_n_r <= rs1_r;
      end
   end
   always_ff @(posedge REF_CLK or negedge BACKUP_RST_N) begin
      if (!BACKUP_RST_N) begin
         bk1_r  <= 1'b0;
         bk_n_r <= 1'b0;
      end else begin
         bk1_r  <= 1'b1;
         bk_n_r <= bk1_r;
      end
   end

   assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

   // address decode
   always_comb begin
      wr_ctrl = 1'b0;
      wr_mode = 1'b0;
      rd_stat = 1'b0;
      if (req.wr && req.addr == `WDG_OFS_CTRL) begin
         wr_ctrl = 1'b1;
      end else if (req.wr && req.addr == `WDG_OFS_MODE) begin
         wr_mode = !mode_locked_r;
      end else if (req.rd && req.addr == `WDG_OFS_STAT) begin
         rd_stat = 1'b1;
      end
   end

   assign restart = wr_ctrl && req.wdata[`WDG_KEY_HI:`WDG_KEY_LO] == `WDG_KEY_VAL
                    && req.wdata[`WDG_RESTART_BIT];
   assign win_err = restart && (cnt_r > mode_r.window_limit)
                    && (mode_r.window_limit < mode_r.reload_value);

   always_comb begin
      if (mode_r.disable_bit) begin
         st = WDG_OFF;
      end else if ((mode_r.debug_halt && DEBUG_STATE) || (mode_r.idle_halt && IDLE_STATE)) begin
         st = WDG_HALT;
      end else begin
         st = WDG_RUN;
      end
   end

   assign tick      = (st == WDG_RUN) && SLOW_TICK && (pre_r == 7'(PRESCALE - 1));
   assign underflow = tick && (cnt_r == 12'h000);

   // mode register, write-once; processor reset restores defaults
   always_ff @(posedge REF_CLK or negedge rs_n_r) begin
      if (!rs_n_r) begin
         mode_r        <= wdg_mode_t'(`WDG_MODE_RESET);
         mode_locked_r <= 1'b0;
      end else if (CLK_EN && wr_mode) begin
         mode_r        <= wdg_mode_t'(req.wdata & `WDG_MODE_MASK);
         mode_locked_r <= 1'b1;
      end
   end

   // fault reset enable lives in the backup domain; a mode write updates it
   always_ff @(posedge REF_CLK or negedge bk_n_r) begin
      if (!bk_n_r) begin
         rst_en_r <= 1'b1;
      end else if (CLK_EN && wr_mode) begin
         rst_en_r <= req.wdata[`WDG_RSTEN_BIT];
      end
   end

   // prescaler and counter
   always_ff @(posedge REF_CLK or negedge rs_n_r) begin
      if (!rs_n_r) begin
         pre_r <= 7'h00;
         cnt_r <= 12'hFFF;
      end else if (CLK_EN) begin
         if (wr_mode) begin
            pre_r <= 7'h00;
            cnt_r <= req.wdata[11:0];
         end else if (restart && !win_err) begin
            pre_r <= 7'h00;
            cnt_r <= mode_r.reload_value;
         end else if (st == WDG_RUN && SLOW_TICK) begin
            pre_r <= (pre_r == 7'(PRESCALE - 1)) ? 7'h00 : pre_r + 7'h01;
            if (tick) begin
               cnt_r <= cnt_r - 12'h001;
            end
         end
      end
   end

   // sticky flags; a new event wins over a clearing read
   always_ff @(posedge REF_CLK or negedge rs_n_r) begin
      if (!rs_n_r) begin
         unf_r       <= 1'b0;
         err_r       <= 1'b0;
         fault_r     <= 1'b0;
         proc_only_r <= 1'b0;
      end else if (CLK_EN) begin
         unf_r   <= underflow | (unf_r & !rd_stat);
         err_r   <= win_err | (err_r & !rd_stat);
         fault_r <= (underflow & rst_en_r) | win_err | (fault_r & !rd_stat);
         if (underflow | win_err) begin
            proc_only_r <= mode_r.proc_only_reset;
         end
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge REF_CLK or negedge rs_n_r) begin
      if (!rs_n_r) begin
         rdata_r <= 32'h00000000;
      end else if (CLK_EN) begin
         rdata_r <= 32'h00000000;
         if (req.rd && req.addr == `WDG_OFS_MODE) begin
            rdata_r <= {mode_r[31:14], rst_en_r, mode_r[12:0]};
         end else if (rd_stat) begin
            rdata_r <= {30'h0, err_r, unf_r};
         end
      end
   end

   assign RDATA           = rdata_r;
   assign IRQ             = mode_r.fault_irq_enable && (unf_r || err_r);
   assign FAULT           = fault_r;
   assign FAULT_PROC_ONLY = fault_r && proc_only_r;
   assign COUNT           = cnt_r;

   // restart is two steps: an accepted keyed write, then a fresh count
   sequence s_good_restart;
      CLK_EN && restart && !win_err;
   endsequence

   sequence s_reloaded;
      cnt_r == $past(mode_r.reload_value) && pre_r == 7'h00;
   endsequence

   property p_irq;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      (CLK_EN && mode_r.fault_irq_enable && (underflow || win_err)) |=> IRQ;
   endproperty
   a_irq: assert property (p_irq) else $error("fault did not raise irq");

   property p_restart;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      s_good_restart |=> s_reloaded;
   endproperty
   a_restart: assert property (p_restart) else $error("restart did not reload");

   property p_lock;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      (mode_locked_r && CLK_EN) |=> $stable(mode_r);
   endproperty
   a_lock: assert property (p_lock) else $error("mode changed after lock");

   property p_unf;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      (CLK_EN && underflow) |=> unf_r;
   endproperty
   a_unf: assert property (p_unf) else $error("underflow not flagged");

   property p_unf_fault;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      (CLK_EN && underflow && rst_en_r) |=> FAULT;
   endproperty
   a_unf_fault: assert property (p_unf_fault) else $error("underflow gave no fault");

   property p_err;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      (CLK_EN && win_err) |=> err_r && FAULT;
   endproperty
   a_err: assert property (p_err) else $error("window error not flagged");

   property p_clear;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      (CLK_EN && rd_stat && !underflow && !win_err) |=> !unf_r && !err_r && !FAULT;
   endproperty
   a_clear: assert property (p_clear) else $error("status read did not clear");

   property p_irq_drop;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      (CLK_EN && rd_stat && !underflow && !win_err) |=> !IRQ;
   endproperty
   a_irq_drop: assert property (p_irq_drop) else $error("irq stayed after clear");

   property p_off;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      (CLK_EN && mode_r.disable_bit && !wr_mode && !restart) |=> $stable(cnt_r);
   endproperty
   a_off: assert property (p_off) else $error("counter moved while disabled");

   property p_mode_load;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      (CLK_EN && wr_mode) |=> cnt_r == $past(req.wdata[11:0]) && pre_r == 7'h00;
   endproperty
   a_mode_load: assert property (p_mode_load) else $error("mode write did not reload");

   // a wrong key must leave the count alone unless a tick lands there
   property p_bad_key;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      (CLK_EN && wr_ctrl && !tick && req.wdata[`WDG_KEY_HI:`WDG_KEY_LO] != `WDG_KEY_VAL)
      |=> cnt_r == $past(cnt_r);
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("unkeyed write acted");

   property p_halt;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      (CLK_EN && st == WDG_HALT && !wr_mode && !restart) |=> $stable(cnt_r) && $stable(pre_r);
   endproperty
   a_halt: assert property (p_halt) else $error("counter moved while halted");

   property p_prescale;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      (CLK_EN && st == WDG_RUN && SLOW_TICK && !tick && !wr_mode && !restart)
      |=> $stable(cnt_r) && pre_r == $past(pre_r) + 7'h01;
   endproperty
   a_prescale: assert property (p_prescale) else $error("count moved between ticks");

   property p_wrap;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      (CLK_EN && underflow && !wr_mode && !restart) |=> cnt_r == 12'hFFF;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap");

   property p_window_off;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      (CLK_EN && restart && mode_r.window_limit >= mode_r.reload_value)
      |=> cnt_r == $past(mode_r.reload_value);
   endproperty
   a_window_off: assert property (p_window_off) else $error("open window refused restart");

   property p_scope;
      @(posedge REF_CLK) disable iff (!rs_n_r)
      (CLK_EN && (underflow || win_err) && mode_r.proc_only_reset) |=> FAULT == FAULT_PROC_ONLY;
   endproperty
   a_scope: assert property (p_scope) else $error("reset scope not latched");
endmodule : wdg_top

// >>> sim/wdg_rstc_model.sv
// reset controller stand-in: counts watchdog faults and their scope
// assumes FAULT levels are in the REF_CLK domain
`timescale 1ns/1ns
module wdg_rstc_model (
   // clock
   input  wire logic clk,
   // fault request from the watchdog
   input  wire logic fault,
   input  wire logic proc_only,
   // observed requests
   output int        faults,
   output logic      scope_r
);
   logic fault_r;
   initial begin
      faults  = 0;
      fault_r = 1'b0;
      scope_r = 1'b0;
   end
   // a held fault is one request, only its rising level counts
   always @(posedge clk) begin
      fault_r <= fault;
      if (fault && !fault_r) begin
         faults  <= faults + 1;
         scope_r <= proc_only;
      end
   end
endmodule : wdg_rstc_model

// >>> sim/testbench.sv
// self-checking bench of the windowed watchdog
// assumes a prescaler of 4 and one slow tick per clock while ticking
`timescale 1ns/1ns
`include "wdg_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module testbench;
   localparam int PS = 4;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        bk_n = 1'b0;
   logic        tick = 1'b0;
   logic        dbg = 1'b0;
   logic        idle = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata;
   logic        irq;
   logic        fault;
   logic        fpo;
   logic [11:0] count;
   logic        scope;
   int          faults;
   int          fail_count = 0;
   int          checks = 0;
   always #20 clk = ~clk;
   wdg_top #(.PRESCALE(PS)) i_wdg_top (.REF_CLK(clk), .RST_N(rst_n), .BACKUP_RST_N(bk_n), .CLK_EN(1'b1),
      .SLOW_TICK(tick), .DEBUG_STATE(dbg), .IDLE_STATE(idle), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .IRQ(irq), .FAULT(fault), .FAULT_PROC_ONLY(fpo), .COUNT(count));
   wdg_rstc_model i_wdg_rstc_model (.clk(clk), .fault(fault), .proc_only(fpo), .faults(faults), .scope_r(scope));
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      #1;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask : rd_chk
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cycles
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   // generous: the sequence needs well under 400 cycles
   initial begin
      repeat (3000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      bk_n  <= 1'b1;
      cycles(3);
      `CHK(count, 12'hFFF)
      rd_chk(`WDG_OFS_MODE, `WDG_MODE_RESET);
      rd_chk(`WDG_OFS_STAT, 32'h0);
      $display("test reset values done");
      wr_reg(`WDG_OFS_MODE, 32'h3004_7008);
      `CHK(count, 12'h008)
      wr_reg(`WDG_OFS_MODE, 32'h0000_0FFF);
      rd_chk(`WDG_OFS_MODE, 32'h3004_7008);
      wr_reg(`WDG_OFS_CTRL, 32'h5A00_0001);
      rd_chk(`WDG_OFS_STAT, 32'h0);
      wr_reg(`WDG_OFS_CTRL, 32'hA500_0000);
      rd_chk(`WDG_OFS_STAT, 32'h0);
      wr_reg(`WDG_OFS_CTRL, 32'hA500_0001);
      cycles(2);
      `CHK({fault, irq, fpo}, 3'b111)
      rd_chk(`WDG_OFS_STAT, 32'h2);
      `CHK({fault, irq}, 2'b00)
      $display("test mode and window done");
      @(posedge clk);
      dbg  <= 1'b1;
      tick <= 1'b1;
      repeat (20) @(posedge clk);
      dbg  <= 1'b0;
      idle <= 1'b1;
      cycles(20);
      `CHK(count, 12'h008)
      idle <= 1'b0;
      for (int i = 0; i < 200 && count !== 12'h003; i++) cycles(1);
      wr_reg(`WDG_OFS_CTRL, 32'hA500_0001);
      `CHK(count, 12'h008)
      cycles(PS - 2);
      `CHK(count, 12'h008)
      cycles(2);
      `CHK(count, 12'h007)
      for (int i = 0; i < 200 && fault !== 1'b1; i++) cycles(1);
      `CHK({fault, irq, fpo}, 3'b111)
      cycles(3);
      `CHK(irq, 1'b1)
      $display("test halt and underflow done");
      rst_n <= 1'b0;
      tick  <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      cycles(3);
      `CHK(fault, 1'b0)
      rd_chk(`WDG_OFS_MODE, `WDG_MODE_RESET);
      rd_chk(`WDG_OFS_STAT, 32'h0);
      wr_reg(`WDG_OFS_CTRL, 32'hA500_0001);
      rd_chk(`WDG_OFS_STAT, 32'h0);
      `CHK(count, 12'hFFF)
      wr_reg(`WDG_OFS_MODE, 32'h0002_8010);
      tick <= 1'b1;
      cycles(20);
      `CHK(count, 12'h010)
      wr_reg(`WDG_OFS_CTRL, 32'hA500_0001);
      cycles(1);
      `CHK({fault, irq}, 2'b10)
      rd_chk(`WDG_OFS_STAT, 32'h2);
      `CHK(faults, 3)
      `CHK(scope, 1'b0)
      $display("test reset and disable done");
      report_and_stop();
   end
endmodule : testbench
